// ==== verilog/sfe_top.sv ====
// Function
// R1: Refuse 32KB erase on protected block
// R2: D8H erases the addressed 64KB block
// R3: Host sends write enable before erases
// R4: 64KB erase frame: opcode plus three bytes
// R5: Select rise after 32nd bit, else discard
// R6: Erase starts on select rise, busy high
// R7: Write latch cleared; status readable while busy
// R8: Refuse 64KB erase on protected block
// R9: 60H or C7H is full erase, opcode only
// R10: Full erase needs select rise after bit 8
// R11: Full erase runs self-timed, busy held high
// R12: Full erase only with all-clear/all-set protection
// R13: Only B9H enters deep sleep
// R14: In sleep only wake and reset accepted
// R15: Sleep needs select rise after bit 8
// R16: Wait entry delay before sleeping
// R17: Sleep refused while a cycle runs
// R18: Power-up always lands in standby
// R19: ABH wakes after the wake delay
// R20: Host keeps select high during wake delay
// R21: ID after three dummy bytes, MSB, repeating
// R22: Host waits longer delay after ID wake; here both wake delays are 3000 ns
// R23: Wake/ID ignored while busy
// R24: Erase without write latch is dropped
`timescale 1ns/10ps
`include "sfe_map.svh"
module sfe_top #(
  parameter int ADDR_W = 22,
  // Device ID value is arbitrary
  parameter logic [7:0] DEVICE_ID = 8'h5a,
  parameter logic [7:0] SOFT_RESET_OP = 8'hf0,
  parameter int SMALL_BLOCK_ERASE_CYCLES = `SFE_SMALL_BLOCK_ERASE_TIME_US * `SFE_CLK_MHZ,
  parameter int LARGE_BLOCK_ERASE_CYCLES = `SFE_LARGE_BLOCK_ERASE_TIME_US * `SFE_CLK_MHZ,
  parameter int FULL_ERASE_CYCLES = `SFE_FULL_ERASE_TIME_US * `SFE_CLK_MHZ
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic si_i,
  input wire logic [4:0] block_protect_bits_i,
  input wire logic protect_complement_i,
  output logic so_o,
  output logic so_oe_o,
  output logic write_in_progress_o,
  output logic write_enable_latch_o,
  output logic deep_sleep_o,
  output logic erase_start_o,
  output logic [1:0] erase_kind_o,
  output logic [23:0] erase_addr_o
);
  localparam int SLEEP_ENTRY_CYCLES = (`SFE_SLEEP_ENTRY_DELAY_NS * `SFE_CLK_MHZ + 999) / 1000;
  localparam int WAKE_CYCLES = (`SFE_WAKE_DELAY_NS * `SFE_CLK_MHZ + 999) / 1000;
  localparam int WAKE_ID_CYCLES = (`SFE_WAKE_WITH_ID_DELAY_NS * `SFE_CLK_MHZ + 999) / 1000;
  localparam int NBLK = 1 << (ADDR_W - 16);

  if (ADDR_W < 17 || ADDR_W > 24) begin : g_bad_addr_w
    $error("sfe_top: ADDR_W must lie in 17..24");
  end
  if (SMALL_BLOCK_ERASE_CYCLES < 1 || LARGE_BLOCK_ERASE_CYCLES < 1 || FULL_ERASE_CYCLES < 1) begin : g_bad_time
    $error("sfe_top: erase cycle counts must be at least 1");
  end

  typedef struct packed {
    sfe_pkg::sfe_state_t state;
    logic write_enable_latch;
    logic write_in_progress;
    logic sleep;
    logic erase_start;
    sfe_pkg::sfe_erase_kind_t erase_kind;
    logic [23:0] erase_addr;
    logic out_en;
    logic [7:0] out_byte;
    logic so;
    logic so_oe;
    logic tmr_load;
    logic [31:0] tmr_count;
  } sfe_top_st_t;

  sfe_top_st_t st_reg, st_next;
  logic tmr_done;
  logic [7:0] status_byte;

  sfe_link_if link ();

  sfe_shifter u_shifter (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .cs_n_i(cs_n_i),
    .sclk_i(sclk_i),
    .si_i(si_i),
    .link(link.shifter)
  );

  sfe_timer u_timer (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .load_i(st_reg.tmr_load),
    .count_i(st_reg.tmr_count),
    .done_o(tmr_done)
  );

  // Block-protect decode: region of 2^(n-1) 64KB blocks at top, or bottom
  // when bit 3 is set; 7 covers all; complement inverts the region.
  function automatic logic block_protected(input logic [4:0] bp, input logic cmp, input logic [23:0] a);
    logic [7:0] blk;
    logic [8:0] size;
    logic hit;
    blk = 8'(a[23:16] & 8'(NBLK - 1));
    size = 9'h0;
    hit = 1'b0;
    if (bp[2:0] == 3'h7) begin
      hit = 1'b1;
    end else if (bp[2:0] != 3'h0) begin
      size = 9'(9'h1 << (bp[2:0] - 3'h1));
      if (bp[3]) begin
        hit = {1'b0, blk} < size;
      end else begin
        hit = {1'b0, blk} >= 9'(NBLK) - size;
      end
    end
    return hit ^ cmp;
  endfunction

  function automatic logic full_erase_allowed(input logic [4:0] bp, input logic cmp);
    return (bp[2:0] == 3'h0 && !cmp) || (bp[2:0] == 3'h7 && cmp); // R12
  endfunction

  always_comb begin
    status_byte = 8'h00;
    status_byte[`SFE_ST_WIP_BIT] = st_reg.write_in_progress;
    status_byte[`SFE_ST_WEL_BIT] = st_reg.write_enable_latch;
    status_byte[`SFE_ST_BP_LSB +: 5] = block_protect_bits_i;
  end

  always_comb begin
    st_next = st_reg;
    st_next.erase_start = 1'b0;
    st_next.tmr_load = 1'b0;
    st_next.so = link.so;
    st_next.out_en = 1'b0;
    st_next.out_byte = st_reg.out_byte;

    // Output selection while selected
    if (link.cs_low && link.bit_cnt >= `SFE_BITS_OPCODE) begin
      if (link.opcode == `SFE_OP_READ_STATUS &&
          (st_reg.state == sfe_pkg::SFE_ST_STANDBY || st_reg.state == sfe_pkg::SFE_ST_BUSY)) begin
        st_next.out_en = 1'b1; // R7
        st_next.out_byte = status_byte;
      end else if (link.opcode == `SFE_OP_WAKE_AND_ID && link.bit_cnt >= `SFE_BITS_ADDR_CMD &&
                   (st_reg.state == sfe_pkg::SFE_ST_STANDBY || st_reg.state == sfe_pkg::SFE_ST_SLEEP)) begin
        st_next.out_en = 1'b1; // R21
        st_next.out_byte = DEVICE_ID;
      end
    end
    st_next.so_oe = st_next.out_en;

    case (st_reg.state)
      sfe_pkg::SFE_ST_STANDBY: begin
        if (link.frame_end) begin
          if (link.bit_cnt == `SFE_BITS_OPCODE) begin
            if (link.opcode == `SFE_OP_WRITE_ENABLE) begin
              st_next.write_enable_latch = 1'b1;
            end else if (link.opcode == `SFE_OP_WRITE_DISABLE || link.opcode == SOFT_RESET_OP) begin
              st_next.write_enable_latch = 1'b0;
            end else if (link.opcode == `SFE_OP_CHIP_ERASE_A || link.opcode == `SFE_OP_CHIP_ERASE_B) begin // R9 R10
              if (st_reg.write_enable_latch && full_erase_allowed(block_protect_bits_i, protect_complement_i)) begin // R24 R12
                st_next.state = sfe_pkg::SFE_ST_BUSY; // R11
                st_next.write_in_progress = 1'b1;
                st_next.write_enable_latch = 1'b0; // R7
                st_next.erase_start = 1'b1;
                st_next.erase_kind = sfe_pkg::SFE_ERASE_CHIP;
                st_next.erase_addr = 24'h000000;
                st_next.tmr_load = 1'b1;
                st_next.tmr_count = 32'(FULL_ERASE_CYCLES);
              end
            end else if (link.opcode == `SFE_OP_DEEP_SLEEP) begin // R13 R15
              st_next.state = sfe_pkg::SFE_ST_SLEEP_ENTRY; // R16
              st_next.tmr_load = 1'b1;
              st_next.tmr_count = 32'(SLEEP_ENTRY_CYCLES);
            end
          end else if (link.bit_cnt == `SFE_BITS_ADDR_CMD &&
                       (link.opcode == `SFE_OP_ERASE_32K || link.opcode == `SFE_OP_ERASE_64K)) begin // R4 R5
            if (st_reg.write_enable_latch &&
                !block_protected(block_protect_bits_i, protect_complement_i, link.addr)) begin // R24 R1 R8
              st_next.state = sfe_pkg::SFE_ST_BUSY; // R6
              st_next.write_in_progress = 1'b1;
              st_next.write_enable_latch = 1'b0; // R7
              st_next.erase_start = 1'b1;
              st_next.tmr_load = 1'b1;
              if (link.opcode == `SFE_OP_ERASE_64K) begin
                st_next.erase_kind = sfe_pkg::SFE_ERASE_64K; // R2
                st_next.erase_addr = {link.addr[23:16], 16'h0000};
                st_next.tmr_count = 32'(LARGE_BLOCK_ERASE_CYCLES);
              end else begin
                st_next.erase_kind = sfe_pkg::SFE_ERASE_32K;
                st_next.erase_addr = {link.addr[23:15], 15'h0000};
                st_next.tmr_count = 32'(SMALL_BLOCK_ERASE_CYCLES);
              end
            end
          end
        end
      end
      sfe_pkg::SFE_ST_BUSY: begin
        // Every command other than status read is dropped here
        if (tmr_done) begin // R17 R23
          st_next.write_in_progress = 1'b0; // R6
          st_next.state = sfe_pkg::SFE_ST_STANDBY;
        end
      end
      sfe_pkg::SFE_ST_SLEEP_ENTRY: begin
        if (tmr_done) begin
          st_next.state = sfe_pkg::SFE_ST_SLEEP; // R16
          st_next.sleep = 1'b1;
        end
      end
      sfe_pkg::SFE_ST_SLEEP: begin
        if (link.frame_end && link.bit_cnt >= `SFE_BITS_OPCODE) begin // R14
          if (link.opcode == `SFE_OP_WAKE_AND_ID) begin
            st_next.state = sfe_pkg::SFE_ST_WAKING; // R19
            st_next.tmr_load = 1'b1;
            if (link.bit_cnt == `SFE_BITS_OPCODE) begin
              st_next.tmr_count = 32'(WAKE_CYCLES);
            end else begin
              st_next.tmr_count = 32'(WAKE_ID_CYCLES);
            end
          end else if (link.opcode == SOFT_RESET_OP && link.bit_cnt == `SFE_BITS_OPCODE) begin
            st_next.state = sfe_pkg::SFE_ST_STANDBY;
            st_next.sleep = 1'b0;
            st_next.write_enable_latch = 1'b0;
          end
        end
      end
      sfe_pkg::SFE_ST_WAKING: begin
        if (tmr_done) begin
          st_next.state = sfe_pkg::SFE_ST_STANDBY; // R19
          st_next.sleep = 1'b0;
        end
      end
      default: begin
        st_next.state = sfe_pkg::SFE_ST_STANDBY;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= '0; // R18
      st_reg.state <= sfe_pkg::SFE_ST_STANDBY;
    end else begin
      st_reg <= st_next;
    end
  end

  // Output byte and enable go back to the shifter, which serialises them
  assign link.out_en = st_reg.out_en;
  assign link.out_byte = st_reg.out_byte;
  assign so_o = st_reg.so;
  assign so_oe_o = st_reg.so_oe;
  assign write_in_progress_o = st_reg.write_in_progress;
  assign write_enable_latch_o = st_reg.write_enable_latch;
  assign deep_sleep_o = st_reg.sleep;
  assign erase_start_o = st_reg.erase_start;
  assign erase_kind_o = st_reg.erase_kind;
  assign erase_addr_o = st_reg.erase_addr;
endmodule // sfe_top

// ==== verilog/sfe_map.svh ====
`ifndef SFE_MAP_SVH
`define SFE_MAP_SVH

// Command opcodes
`define SFE_OP_WRITE_ENABLE 8'h06
`define SFE_OP_WRITE_DISABLE 8'h04
`define SFE_OP_READ_STATUS 8'h05
`define SFE_OP_ERASE_32K 8'h52
`define SFE_OP_ERASE_64K 8'hd8
`define SFE_OP_CHIP_ERASE_A 8'h60
`define SFE_OP_CHIP_ERASE_B 8'hc7
`define SFE_OP_DEEP_SLEEP 8'hb9
`define SFE_OP_WAKE_AND_ID 8'hab

// Frame lengths in bits at select rise
`define SFE_BITS_OPCODE 6'd8
`define SFE_BITS_ADDR_CMD 6'd32
`define SFE_BITS_SAT 6'h3f

// Status byte field positions
`define SFE_ST_WIP_BIT 0
`define SFE_ST_WEL_BIT 1
`define SFE_ST_BP_LSB 2

// Clock rate and times
`define SFE_CLK_MHZ 250
`define SFE_SMALL_BLOCK_ERASE_TIME_US 150
`define SFE_LARGE_BLOCK_ERASE_TIME_US 300
`define SFE_FULL_ERASE_TIME_US 2000
`define SFE_SLEEP_ENTRY_DELAY_NS 3000
`define SFE_WAKE_DELAY_NS 3000
`define SFE_WAKE_WITH_ID_DELAY_NS 3000

`endif

// ==== verilog/sfe_pkg.sv ====
package sfe_pkg;

  typedef enum logic [2:0] {
    SFE_ST_STANDBY = 3'b000,
    SFE_ST_BUSY = 3'b001,
    SFE_ST_SLEEP_ENTRY = 3'b010,
    SFE_ST_SLEEP = 3'b011,
    SFE_ST_WAKING = 3'b100
  } sfe_state_t;

  typedef enum logic [1:0] {
    SFE_ERASE_32K = 2'b00,
    SFE_ERASE_64K = 2'b01,
    SFE_ERASE_CHIP = 2'b10
  } sfe_erase_kind_t;

endpackage

// ==== verilog/sfe_link_if.sv ====
`timescale 1ns/10ps
interface sfe_link_if;
  logic cs_low;
  logic op_stb;
  logic frame_end;
  logic [7:0] opcode;
  logic [5:0] bit_cnt;
  logic [23:0] addr;
  logic out_en;
  logic [7:0] out_byte;
  logic so;

  modport shifter (
    output cs_low, op_stb, frame_end, opcode, bit_cnt, addr, so,
    input out_en, out_byte
  );
  modport core (
    input cs_low, op_stb, frame_end, opcode, bit_cnt, addr, so,
    output out_en, out_byte
  );
endinterface

// ==== verilog/sfe_shifter.sv ====
`timescale 1ns/10ps
`include "sfe_map.svh"
module sfe_shifter (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic si_i,
  sfe_link_if.shifter link
);
  typedef struct packed {
    logic cs_s1, cs_s2, cs_d;
    logic ck_s1, ck_s2, ck_d;
    logic si_s1, si_s2;
    logic [31:0] shreg;
    logic [5:0] cnt;
    logic [7:0] opcode;
    logic op_stb, frame_end;
    logic [7:0] out_sh;
    logic [2:0] out_cnt;
    logic so;
  } sfe_shift_st_t;

  sfe_shift_st_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.op_stb = 1'b0;
    st_next.frame_end = 1'b0;
    st_next.cs_s1 = cs_n_i;
    st_next.cs_s2 = st_reg.cs_s1;
    st_next.cs_d = st_reg.cs_s2;
    st_next.ck_s1 = sclk_i;
    st_next.ck_s2 = st_reg.ck_s1;
    st_next.ck_d = st_reg.ck_s2;
    st_next.si_s1 = si_i;
    st_next.si_s2 = st_reg.si_s1;
    if (st_reg.cs_d && !st_reg.cs_s2) begin
      st_next.cnt = 6'h00;
      st_next.out_cnt = 3'h0;
      st_next.so = 1'b0;
    end else if (!st_reg.cs_s2) begin
      if (st_reg.ck_s2 && !st_reg.ck_d) begin
        st_next.shreg = {st_reg.shreg[30:0], st_reg.si_s2};
        if (st_reg.cnt != `SFE_BITS_SAT) begin
          st_next.cnt = st_reg.cnt + 6'h01;
        end
        if (st_reg.cnt == `SFE_BITS_OPCODE - 6'h01) begin
          st_next.opcode = {st_reg.shreg[6:0], st_reg.si_s2};
          st_next.op_stb = 1'b1;
        end
      end
      // Output bits change on falling clock edges, MSB first, repeating
      if (!st_reg.ck_s2 && st_reg.ck_d && link.out_en) begin
        if (st_reg.out_cnt == 3'h0) begin
          st_next.so = link.out_byte[7];
          st_next.out_sh = {link.out_byte[6:0], 1'b0};
          st_next.out_cnt = 3'h7;
        end else begin
          st_next.so = st_reg.out_sh[7];
          st_next.out_sh = {st_reg.out_sh[6:0], 1'b0};
          st_next.out_cnt = st_reg.out_cnt - 3'h1;
        end
      end
    end
    if (!st_reg.cs_d && st_reg.cs_s2) begin
      st_next.frame_end = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= '0;
      st_reg.cs_s1 <= 1'b1;
      st_reg.cs_s2 <= 1'b1;
      st_reg.cs_d <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.cs_low = !st_reg.cs_s2;
  assign link.op_stb = st_reg.op_stb;
  assign link.frame_end = st_reg.frame_end;
  assign link.opcode = st_reg.opcode;
  assign link.bit_cnt = st_reg.cnt;
  assign link.addr = st_reg.shreg[23:0];
  assign link.so = st_reg.so;
endmodule // sfe_shifter

// ==== verilog/sfe_timer.sv ====
`timescale 1ns/10ps
module sfe_timer (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic load_i,
  input wire logic [31:0] count_i,
  output logic done_o
);
  typedef struct packed {
    logic [31:0] cnt;
    logic busy;
    logic done;
  } sfe_timer_st_t;

  sfe_timer_st_t st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (load_i) begin
      st_next.cnt = count_i;
      st_next.busy = 1'b1;
    end else if (st_reg.busy) begin
      if (st_reg.cnt <= 32'h1) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
        st_next.cnt = 32'h0;
      end else begin
        st_next.cnt = st_reg.cnt - 32'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign done_o = st_reg.done;
endmodule // sfe_timer

// ==== test/sfe_top_chk.sv ====
`timescale 1ns/10ps
module sfe_top_chk (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cs_n_i,
  input wire logic [4:0] block_protect_bits_i,
  input wire logic protect_complement_i,
  input wire logic so_oe_o,
  input wire logic write_in_progress_o,
  input wire logic write_enable_latch_o,
  input wire logic deep_sleep_o,
  input wire logic erase_start_o,
  input wire logic [1:0] erase_kind_o,
  input wire logic [23:0] erase_addr_o
);
  logic [9:0] cs_hi_reg;
  logic [9:0] cs_hi_next;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // Cycles that select has stayed high, saturating
  always_comb begin
    cs_hi_next = cs_hi_reg;
    if (!cs_n_i) cs_hi_next = 10'h0;
    else if (cs_hi_reg != 10'h3ff) cs_hi_next = cs_hi_reg + 10'h1;
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) cs_hi_reg <= 10'h0;
    else cs_hi_reg <= cs_hi_next;
  end
  property p_start_busy;
    erase_start_o |-> ##[0:1] write_in_progress_o;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy not set at erase start");
  property p_start_wel;
    erase_start_o |-> ##[0:1] !write_enable_latch_o;
  endproperty
  a_start_wel: assert property (p_start_wel) else $error("write latch kept at erase start");
  property p_start_latch;
    erase_start_o |-> $past(write_enable_latch_o);
  endproperty
  a_start_latch: assert property (p_start_latch) else $error("erase started without latch");
  property p_kind_hold;
    !erase_start_o && !$past(erase_start_o) |-> $stable(erase_kind_o) && $stable(erase_addr_o);
  endproperty
  a_kind_hold: assert property (p_kind_hold) else $error("erase kind or base moved");
  property p_base;
    write_in_progress_o && $past(write_in_progress_o) |->
      (erase_kind_o == 2'h2) ? (erase_addr_o == 24'h0) :
      (erase_addr_o[14:0] == 15'h0 && (erase_kind_o == 2'h0 || !erase_addr_o[15]));
  endproperty
  a_base: assert property (p_base) else $error("erase base not aligned");
  property p_full_prot;
    $rose(write_in_progress_o) ##1 (erase_kind_o == 2'h2) |->
      (block_protect_bits_i[2:0] == 3'h0 && !protect_complement_i) ||
      (block_protect_bits_i[2:0] == 3'h7 && protect_complement_i);
  endproperty
  a_full_prot: assert property (p_full_prot) else $error("full erase under protection");
  property p_sleep_quiet;
    deep_sleep_o |-> !write_in_progress_o && !erase_start_o;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("activity in deep sleep");
  property p_sleep_entry;
    $rose(deep_sleep_o) |-> cs_hi_reg >= 10'h2e4;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entered too early");
  property p_wake;
    $fell(deep_sleep_o) |-> cs_hi_reg >= 10'h2e4;
  endproperty
  a_wake: assert property (p_wake) else $error("woke too early");
  property p_oe_idle;
    cs_hi_reg >= 10'h5 |-> !so_oe_o;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output driven while deselected");
endmodule // sfe_top_chk
bind sfe_top sfe_top_chk sfe_top_chk_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .cs_n_i(cs_n_i),
  .block_protect_bits_i(block_protect_bits_i), .protect_complement_i(protect_complement_i), .so_oe_o(so_oe_o),
  .write_in_progress_o(write_in_progress_o), .write_enable_latch_o(write_enable_latch_o),
  .deep_sleep_o(deep_sleep_o), .erase_start_o(erase_start_o), .erase_kind_o(erase_kind_o),
  .erase_addr_o(erase_addr_o));

// ==== test/sfe_host_model.sv ====
`timescale 1ns/10ps
module sfe_host_model (
  output logic cs_n_o,
  output logic sclk_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
  end
  // Mode 0 frame, msb first; the clock stands low between frames
  task automatic xfer(input logic [63:0] d, input int n, output logic [63:0] q);
    q = 64'h0;
    #3.3 cs_n_o = 1'b0;
    #40;
    for (int i = n - 1; i >= 0; i--) begin
      si_o = d[i];
      #16 sclk_o = 1'b1;
      #15.9 q = {q[62:0], so_oe_i & so_i};
      #0.1 sclk_o = 1'b0;
    end
    #40 cs_n_o = 1'b1;
    // Released data line shows the inverse of its last bit
    si_o = ~si_o;
    #60;
  endtask
endmodule // sfe_host_model

// ==== test/sfe_top_tb.sv ====
`timescale 1ns/10ps
module sfe_top_tb;
  typedef struct {
    logic [31:0] d;
    int nb;
    logic [4:0] bp;
    logic cmp;
    logic go;
    logic [1:0] k;
    logic [23:0] base;
  } sfe_row_t;
  logic clk_i, arst_n_i, cs_n, sclk, si, cmp, so, so_oe, write_in_progress, write_enable_latch, sleep, start;
  logic [4:0] bp;
  logic [1:0] kind;
  logic [23:0] eaddr;
  logic [63:0] q;
  sfe_row_t rows [10];
  int error_cnt, samples_checked, cyc, starts, n;
  // Device ID value is arbitrary
  sfe_top #(.SMALL_BLOCK_ERASE_CYCLES(60), .LARGE_BLOCK_ERASE_CYCLES(80), .FULL_ERASE_CYCLES(1200),
    .DEVICE_ID(8'h3c)) sfe_top_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .cs_n_i(cs_n), .sclk_i(sclk),
    .si_i(si), .block_protect_bits_i(bp), .protect_complement_i(cmp), .so_o(so), .so_oe_o(so_oe),
    .write_in_progress_o(write_in_progress), .write_enable_latch_o(write_enable_latch), .deep_sleep_o(sleep),
    .erase_start_o(start), .erase_kind_o(kind), .erase_addr_o(eaddr));
  sfe_host_model host_i (.cs_n_o(cs_n), .sclk_o(sclk), .si_o(si), .so_i(so), .so_oe_i(so_oe));
  task automatic results();
    $display("Checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 2000 && write_in_progress !== 1'b0; k++) @(posedge clk_i);
    chk("idle", 32'h0, write_in_progress);
  endtask
  task automatic wait_sleep(input logic v);
    for (int k = 0; k < 1000 && sleep !== v; k++) @(posedge clk_i);
    chk("sleep", v, sleep);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      results();
    end
  end
  // Pulse counted away from the edge that launches it
  always @(negedge clk_i) begin
    if (start === 1'b1) begin
      starts++;
    end
  end
  initial begin
    rows = '{'{32'hd801a345, 32, 5'h00, 1'b0, 1'b1, 2'h1, 24'h010000},
      '{32'h5201a345, 32, 5'h00, 1'b0, 1'b1, 2'h0, 24'h018000},
      '{32'h00000060, 8, 5'h00, 1'b0, 1'b1, 2'h2, 24'h0},
      '{32'h000000c7, 8, 5'h07, 1'b1, 1'b1, 2'h2, 24'h0},
      '{32'h000000c7, 8, 5'h01, 1'b0, 1'b0, 2'h2, 24'h0},
      '{32'h00000060, 8, 5'h07, 1'b0, 1'b0, 2'h2, 24'h0},
      '{32'hd83f1234, 32, 5'h01, 1'b0, 1'b0, 2'h1, 24'h0},
      '{32'hd8001234, 32, 5'h01, 1'b0, 1'b1, 2'h1, 24'h0},
      '{32'h523f8000, 32, 5'h01, 1'b0, 1'b0, 2'h0, 24'h0},
      '{32'h523f8000, 32, 5'h01, 1'b1, 1'b1, 2'h0, 24'h3f8000}};
    arst_n_i = 1'b0;
    bp = 5'h00;
    cmp = 1'b0;
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("reset_state", 32'h0, {write_in_progress, write_enable_latch, sleep});
    foreach (rows[i]) begin
      @(posedge clk_i);
      bp <= rows[i].bp;
      cmp <= rows[i].cmp;
      host_i.xfer(64'h06, 8, q);
      chk("wel_set", 32'h1, write_enable_latch);
      n = starts;
      host_i.xfer({32'h0, rows[i].d}, rows[i].nb, q);
      repeat (8) @(posedge clk_i);
      chk("erase_started", rows[i].go, starts - n);
      chk("busy", rows[i].go, write_in_progress);
      chk("wel_after", !rows[i].go, write_enable_latch);
      if (rows[i].go) begin
        chk("kind", rows[i].k, kind);
        chk("base", rows[i].base, eaddr);
        wait_idle();
      end
    end
    host_i.xfer(64'h04, 8, q);
    n = starts;
    host_i.xfer(64'hd8000000, 32, q);
    host_i.xfer(64'h06, 8, q);
    host_i.xfer(64'h6c000000, 31, q);
    host_i.xfer(64'h0c0, 9, q);
    repeat (8) @(posedge clk_i);
    chk("dropped", 32'h0, starts - n);
    chk("wel_kept", 32'h1, write_enable_latch);
    @(posedge clk_i);
    bp <= 5'h00;
    cmp <= 1'b0;
    host_i.xfer(64'h60, 8, q);
    host_i.xfer(64'h0500, 16, q);
    chk("status_busy", 32'h01, q[7:0]);
    host_i.xfer(64'hab00000000, 40, q);
    chk("id_busy", 32'h0, q[7:0]);
    host_i.xfer(64'hb9, 8, q);
    wait_idle();
    repeat (800) @(posedge clk_i);
    chk("sleep_busy", 32'h0, sleep);
    host_i.xfer(64'hb9, 8, q);
    repeat (680) @(posedge clk_i);
    chk("sleep_early", 32'h0, sleep);
    wait_sleep(1'b1);
    host_i.xfer(64'h06, 8, q);
    host_i.xfer(64'h60, 8, q);
    repeat (8) @(posedge clk_i);
    chk("wel_sleep", 32'h0, write_enable_latch);
    chk("busy_sleep", 32'h0, write_in_progress);
    host_i.xfer(64'hab, 8, q);
    repeat (680) @(posedge clk_i);
    chk("wake_early", 32'h1, sleep);
    wait_sleep(1'b0);
    repeat (100) @(posedge clk_i);
    host_i.xfer(64'hab0000000000, 48, q);
    chk("id", 32'h3c3c, q[15:0]);
    host_i.xfer(64'hb9, 8, q);
    wait_sleep(1'b1);
    // Wake with ID readout, then the same wait as after a plain wake before the next command
    host_i.xfer(64'hab00000000, 40, q);
    chk("id_sleep", 32'h3c, q[7:0]);
    repeat (680) @(posedge clk_i);
    chk("wake_id_early", 32'h1, sleep);
    wait_sleep(1'b0);
    repeat (100) @(posedge clk_i);
    host_i.xfer(64'h06, 8, q);
    chk("wel_before_reset", 32'h1, write_enable_latch);
    host_i.xfer(64'hf0, 8, q);
    chk("wel_soft_reset", 32'h0, write_enable_latch);
    host_i.xfer(64'hb9, 8, q);
    wait_sleep(1'b1);
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("sleep_reset", 32'h0, sleep);
    results();
  end
endmodule // sfe_top_tb
